// ---- rtl/etc_core.sv ----
module etc_core
  import etc_pkg::*;
(
  // Clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  // Control writes
  input  wire logic                 CONTROL_A_WR,
  input  wire etc_pkg::etc_ctrl_a_s CONTROL_A_DATA,
  input  wire logic                 CONTROL_B_WR,
  input  wire etc_pkg::etc_ctrl_b_s CONTROL_B_DATA,
  // Counter and compare writes
  input  wire logic                 COUNTER_WR,
  input  wire logic [7:0]           COUNTER_WDATA,
  input  wire logic                 COMPARE_A_WR,
  input  wire logic                 COMPARE_B_WR,
  input  wire logic [7:0]           COMPARE_WDATA,
  // Flag and mask writes
  input  wire logic                 MASK_WR,
  input  wire logic [2:0]           MASK_WDATA,
  input  wire logic                 FLAG_WR,
  input  wire logic [2:0]           FLAG_WDATA,
  input  wire logic [2:0]           IRQ_ACK,
  // Tick sources
  input  wire logic [3:0]           PRESCALE_TICK,
  input  wire logic                 EXT_COUNT_PIN,
  // Read back
  output etc_pkg::etc_ctrl_a_s      TIMER_CONTROL_A,
  output etc_pkg::etc_ctrl_b_s      TIMER_CONTROL_B,
  output logic [7:0]                COUNTER_VALUE,
  output logic [7:0]                COMPARE_A_VALUE,
  output logic [7:0]                COMPARE_B_VALUE,
  output logic [2:0]                TIMER_FLAG_REG,
  output logic [2:0]                TIMER_MASK_REG,
  // Interrupts and waveforms
  output logic [2:0]                IRQ,
  output logic                      COMPARE_A_OUTPUT,
  output logic                      COMPARE_B_OUTPUT
);

  // ==========================================================
  // Registers
  etc_ctrl_a_s ctl_a_r;
  etc_ctrl_b_s ctl_b_r;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic        dir_r;
  logic        dir_nxt;
  logic        blk_r;
  logic [2:0]  flag_r;
  logic [2:0]  flag_nxt;
  logic [2:0]  mask_r;
  logic [2:0]  mask_nxt;
  logic [2:0]  irq_r;
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic        ext_s3_r;
  logic        ext_lvl_r;
  logic [7:0]  ocr_r [2];
  logic [7:0]  buf_r [2];
  logic [7:0]  view_r [2];
  logic [1:0]  oc_w;

  // ==========================================================
  // Mode decode
  etc_wave_e  wave;
  etc_class_e cls;
  wire        is_fast  = (wave == WM_FAST_MAX) || (wave == WM_FAST_OCRA);
  wire        is_phase = (wave == WM_PC_MAX) || (wave == WM_PC_OCRA);
  wire        is_pwm   = is_fast || is_phase;
  wire        top_ocra = (wave == WM_CTC) || (wave == WM_FAST_OCRA) ||
                         (wave == WM_PC_OCRA);
  wire [7:0]  top_val  = top_ocra ? ocr_r[0] : CNT_MAX;

  assign wave = etc_wave_e'({ctl_b_r.wave_mode_bit2, ctl_a_r.wave_mode_bit1,
                             ctl_a_r.wave_mode_bit0});
  assign cls  = is_fast ? CL_FAST : (is_phase ? CL_PHASE : CL_NONPWM);

  // ==========================================================
  // Top and bottom indications
  wire at_top    = (cnt_r == top_val);
  wire at_bottom = (cnt_r == CNT_BOTTOM);
  wire at_max    = (cnt_r == CNT_MAX);

  // ==========================================================
  // Tick selection
  wire [2:0] cs       = ctl_b_r.clock_select_field;
  wire [1:0] pre_idx  = 2'(cs - CS_PRE_LO);
  wire       pre_sel  = (cs >= CS_PRE_LO) && (cs <= CS_PRE_HI);
  wire       ext_ok   = (ext_s2_r == ext_s3_r);
  wire       ext_rise = ext_ok && ext_s3_r && !ext_lvl_r;
  wire       ext_fall = ext_ok && !ext_s3_r && ext_lvl_r;
  wire       tick     = (cs == CS_SYS) ||
                        (pre_sel && PRESCALE_TICK[pre_idx]) ||
                        (cs == CS_EXT_FALL && ext_fall) ||
                        (cs == CS_EXT_RISE && ext_rise);

  // ==========================================================
  // Counter sequence
  wire run      = tick && !COUNTER_WR;
  wire turn_dn  = dir_r ? !at_bottom : at_top;
  wire ctc_clr  = (wave == WM_CTC) && at_top;
  wire fast_clr = is_fast && at_top;
  wire ovf_ev   = run && (is_fast ? at_top :
                          is_phase ? (at_bottom && dir_r) : at_max);
  wire upd_ev   = run && at_top && (is_fast || !dir_r);
  wire wrap_ev  = run && fast_clr;

  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (COUNTER_WR) begin
      cnt_nxt = COUNTER_WDATA;
    end else if (tick) begin
      if (ctc_clr || fast_clr) begin
        cnt_nxt = CNT_BOTTOM;
        dir_nxt = 1'b0;
      end else if (is_phase) begin
        cnt_nxt = turn_dn ? 8'(cnt_r - 8'h01) : 8'(cnt_r + 8'h01);
        dir_nxt = turn_dn;
      end else begin
        cnt_nxt = 8'(cnt_r + 8'h01);
        dir_nxt = 1'b0;
      end
    end
  end

  // ==========================================================
  // Compare, blocking and force
  logic [1:0] match_ev;
  logic [1:0] force_ev;
  logic [1:0] cmp_wr;
  logic [1:0] com [2];
  assign cmp_wr   = {COMPARE_B_WR, COMPARE_A_WR};
  assign com[0]   = ctl_a_r.com_a;
  assign com[1]   = ctl_a_r.com_b;
  assign force_ev = {CONTROL_B_WR && CONTROL_B_DATA.force_b && !is_pwm,
                     CONTROL_B_WR && CONTROL_B_DATA.force_a && !is_pwm};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      assign match_ev[i] = run && !blk_r && (cnt_r == ocr_r[i]);

      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          ocr_r[i]  <= CMP_RST;
          buf_r[i]  <= CMP_RST;
          view_r[i] <= CMP_RST;
        end else begin
          if (cmp_wr[i]) buf_r[i] <= COMPARE_WDATA;
          if (cmp_wr[i] && !is_pwm) ocr_r[i] <= COMPARE_WDATA;
          else if (upd_ev && is_pwm) ocr_r[i] <= buf_r[i];
          view_r[i] <= is_pwm ? buf_r[i] : ocr_r[i];
        end
      end

      etc_wave_gen u_wave (
        .clk      (CLK_SYS),
        .rst      (RST),
        .cls      (cls),
        .com      (com[i]),
        .match_ev (match_ev[i]),
        .force_ev (force_ev[i]),
        .wrap_ev  (wrap_ev),
        .dir_down (dir_r),
        .oc       (oc_w[i])
      );
    end
  endgenerate

  // ==========================================================
  // Flags, mask and interrupts
  wire [2:0] flag_set = {match_ev[1], match_ev[0], ovf_ev};
  wire [2:0] flag_clr = (FLAG_WR ? FLAG_WDATA : 3'h0) | IRQ_ACK;
  assign flag_nxt = flag_set | (flag_r & ~flag_clr);
  assign mask_nxt = MASK_WR ? MASK_WDATA : mask_r;

  // ==========================================================
  // State update
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctl_a_r <= CTRL_A_RST;
      ctl_b_r <= CTRL_B_RST;
      cnt_r   <= CNT_RST;
      dir_r   <= 1'b0;
      blk_r   <= 1'b0;
      flag_r  <= FLAG_RST;
      mask_r  <= MASK_RST;
      irq_r   <= 3'h0;
    end else begin
      if (CONTROL_A_WR) ctl_a_r <= CONTROL_A_DATA;
      if (CONTROL_B_WR) ctl_b_r <= '{force_a: 1'b0, force_b: 1'b0,
                                     wave_mode_bit2: CONTROL_B_DATA.wave_mode_bit2,
                                     clock_select_field: CONTROL_B_DATA.clock_select_field};
      cnt_r  <= cnt_nxt;
      dir_r  <= dir_nxt;
      blk_r  <= COUNTER_WR || (blk_r && !tick);
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      irq_r  <= flag_nxt & mask_nxt;
    end
  end

  // External pin synchroniser
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
      ext_s3_r  <= 1'b0;
      ext_lvl_r <= 1'b0;
    end else begin
      ext_s1_r  <= EXT_COUNT_PIN;
      ext_s2_r  <= ext_s1_r;
      ext_s3_r  <= ext_s2_r;
      ext_lvl_r <= ext_ok ? ext_s3_r : ext_lvl_r;
    end
  end

  // ==========================================================
  // Outputs
  assign TIMER_CONTROL_A  = ctl_a_r;
  assign TIMER_CONTROL_B  = ctl_b_r;
  assign COUNTER_VALUE    = cnt_r;
  assign COMPARE_A_VALUE  = view_r[0];
  assign COMPARE_B_VALUE  = view_r[1];
  assign TIMER_FLAG_REG   = flag_r;
  assign TIMER_MASK_REG   = mask_r;
  assign IRQ              = irq_r;
  assign COMPARE_A_OUTPUT = oc_w[0];
  assign COMPARE_B_OUTPUT = oc_w[1];

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_write_wins: assert property (
    COUNTER_WR |=> cnt_r == $past(COUNTER_WDATA))
    else $error("counter write not taken");

  a_stop_holds: assert property (
    (cs == CS_STOP && !COUNTER_WR) |=> cnt_r == $past(cnt_r))
    else $error("counter moved while stopped");

  a_normal_wrap: assert property (
    (run && wave == WM_NORMAL && at_max) |=> (cnt_r == CNT_BOTTOM) && flag_r[FLG_OVF])
    else $error("normal wrap or overflow wrong");

  a_ctc_clear: assert property (
    (run && wave == WM_CTC && cnt_r == ocr_r[0]) |=> cnt_r == CNT_BOTTOM)
    else $error("clear on match failed");

  a_match_flag: assert property (
    match_ev[0] |=> flag_r[FLG_CMPA])
    else $error("compare A flag not set");

  a_match_flag_b: assert property (
    match_ev[1] |=> flag_r[FLG_CMPB])
    else $error("compare B flag not set");

  a_block_match: assert property (
    (COUNTER_WR ##1 (!COUNTER_WR && !tick)[*2] ##1 tick) |-> match_ev == 2'b00)
    else $error("match not blocked after counter write");

  a_flag_clear: assert property (
    (IRQ_ACK[FLG_OVF] && !ovf_ev) |=> !flag_r[FLG_OVF])
    else $error("overflow flag not cleared");

  a_irq_gate: assert property (
    (IRQ & ~TIMER_MASK_REG) == 3'h0)
    else $error("interrupt passed a clear mask bit");

  a_force_noflag: assert property (
    (force_ev[0] && !match_ev[0] && !flag_r[FLG_CMPA]) |=> !flag_r[FLG_CMPA])
    else $error("force strobe set a flag");

  a_pwm_buffer: assert property (
    (is_pwm && (COMPARE_A_WR || COMPARE_B_WR) && !upd_ev) |=>
    (ocr_r[0] == $past(ocr_r[0])) && (ocr_r[1] == $past(ocr_r[1])))
    else $error("PWM compare updated outside top");

  a_direct_write: assert property (
    (!is_pwm && COMPARE_B_WR) |=> ocr_r[1] == $past(COMPARE_WDATA))
    else $error("direct compare write lost");

endmodule

// ---- common/etc_pkg.sv ----
package etc_pkg;

  // ==========================================================
  // Counter limits and reset values
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_RST    = 8'h00;
  localparam logic [7:0] CMP_RST    = 8'h00;
  localparam logic [2:0] FLAG_RST   = 3'h0;
  localparam logic [2:0] MASK_RST   = 3'h0;

  // ==========================================================
  // Flag and mask bit positions
  localparam int FLG_OVF  = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;

  // ==========================================================
  // Clock select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_SYS      = 3'h1;
  localparam logic [2:0] CS_PRE_LO   = 3'h2;
  localparam logic [2:0] CS_PRE_HI   = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // ==========================================================
  // Compare output mode codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // ==========================================================
  // Waveform modes
  typedef enum logic [2:0] {
    WM_NORMAL    = 3'b000,
    WM_PC_MAX    = 3'b001,
    WM_CTC       = 3'b010,
    WM_FAST_MAX  = 3'b011,
    WM_RSV4      = 3'b100,
    WM_PC_OCRA   = 3'b101,
    WM_RSV6      = 3'b110,
    WM_FAST_OCRA = 3'b111
  } etc_wave_e;

  typedef enum logic [1:0] {
    CL_NONPWM = 2'b00,
    CL_FAST   = 2'b01,
    CL_PHASE  = 2'b10
  } etc_class_e;

  // ==========================================================
  // Control registers
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic       wave_mode_bit1;
    logic       wave_mode_bit0;
  } etc_ctrl_a_s;

  typedef struct packed {
    logic       force_a;
    logic       force_b;
    logic       wave_mode_bit2;
    logic [2:0] clock_select_field;
  } etc_ctrl_b_s;

  localparam etc_ctrl_a_s CTRL_A_RST = '{default: '0};
  localparam etc_ctrl_b_s CTRL_B_RST = '{default: '0};

endpackage

// ---- rtl/etc_wave_gen.sv ----
module etc_wave_gen
  import etc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Events and setup
  input  wire etc_class_e cls,
  input  wire logic [1:0] com,
  input  wire logic       match_ev,
  input  wire logic       force_ev,
  input  wire logic       wrap_ev,
  input  wire logic       dir_down,
  // Compare output state
  output logic            oc
);

  // ==========================================================
  // Output state update
  logic oc_nxt;

  always_comb begin
    oc_nxt = oc;
    case (cls)
      CL_NONPWM: begin
        if (match_ev || force_ev) begin
          case (com)
            COM_TOGGLE: oc_nxt = ~oc;
            COM_CLEAR:  oc_nxt = 1'b0;
            COM_SET:    oc_nxt = 1'b1;
            default:    oc_nxt = oc;
          endcase
        end
      end
      CL_FAST: begin
        if (match_ev && com == COM_CLEAR) oc_nxt = 1'b0;
        if (match_ev && com == COM_SET) oc_nxt = 1'b1;
        if (wrap_ev && com == COM_CLEAR) oc_nxt = 1'b1;
        if (wrap_ev && com == COM_SET) oc_nxt = 1'b0;
      end
      CL_PHASE: begin
        if (match_ev && com == COM_CLEAR) oc_nxt = dir_down;
        if (match_ev && com == COM_SET) oc_nxt = ~dir_down;
      end
      default: oc_nxt = oc;
    endcase
  end

  // Mode switches leave the state alone; reset clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) oc <= 1'b0;
    else oc <= oc_nxt;
  end

endmodule

// ---- dv/etc_tb.sv ----
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import etc_pkg::*;

  // ==========================================================
  // Bench signals
  logic        clk_sys;
  logic        rst;
  logic        ctl_a_wr;
  etc_ctrl_a_s ctl_a;
  logic        ctl_b_wr;
  etc_ctrl_b_s ctl_b;
  logic        cnt_wr;
  logic [7:0]  cnt_wdata;
  logic        cmp_a_wr;
  logic        cmp_b_wr;
  logic [7:0]  cmp_wdata;
  logic        mask_wr;
  logic [2:0]  mask_wdata;
  logic        flag_wr;
  logic [2:0]  flag_wdata;
  logic [2:0]  irq_ack;
  logic [3:0]  pre_tick;
  logic        ext_pin;
  etc_ctrl_a_s ctl_a_rd;
  etc_ctrl_b_s ctl_b_rd;
  logic [7:0]  counter_value;
  logic [7:0]  cmp_a_rd;
  logic [7:0]  cmp_b_rd;
  logic [2:0]  flags;
  logic [2:0]  mask_rd;
  logic [2:0]  irq;
  logic        out_a;
  logic        out_b;
  int          num_errors;
  int          n_tests;

  etc_core etc_core_inst (
    .CLK_SYS(clk_sys), .RST(rst),
    .CONTROL_A_WR(ctl_a_wr), .CONTROL_A_DATA(ctl_a),
    .CONTROL_B_WR(ctl_b_wr), .CONTROL_B_DATA(ctl_b),
    .COUNTER_WR(cnt_wr), .COUNTER_WDATA(cnt_wdata),
    .COMPARE_A_WR(cmp_a_wr), .COMPARE_B_WR(cmp_b_wr), .COMPARE_WDATA(cmp_wdata),
    .MASK_WR(mask_wr), .MASK_WDATA(mask_wdata),
    .FLAG_WR(flag_wr), .FLAG_WDATA(flag_wdata), .IRQ_ACK(irq_ack),
    .PRESCALE_TICK(pre_tick), .EXT_COUNT_PIN(ext_pin),
    .TIMER_CONTROL_A(ctl_a_rd), .TIMER_CONTROL_B(ctl_b_rd),
    .COUNTER_VALUE(counter_value),
    .COMPARE_A_VALUE(cmp_a_rd), .COMPARE_B_VALUE(cmp_b_rd),
    .TIMER_FLAG_REG(flags), .TIMER_MASK_REG(mask_rd),
    .IRQ(irq), .COMPARE_A_OUTPUT(out_a), .COMPARE_B_OUTPUT(out_b)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Drivers
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic set_ctrl(input logic [2:0] wm, input logic [2:0] cs, input logic [1:0] com,
                          input logic frc);
    @(negedge clk_sys);
    ctl_a_wr = 1'b1;
    ctl_a = {com, com, wm[1], wm[0]};
    ctl_b_wr = 1'b1;
    ctl_b = {frc, frc, wm[2], cs};
    @(negedge clk_sys);
    ctl_a_wr = 1'b0;
    ctl_b_wr = 1'b0;
  endtask

  // Sel: 0 counter, 1 compare A, 2 compare B, 3 mask, 4 flag clear, 5 ack
  task automatic poke(input int sel, input logic [7:0] v);
    @(negedge clk_sys);
    cnt_wdata = v;
    cmp_wdata = v;
    mask_wdata = v[2:0];
    flag_wdata = v[2:0];
    cnt_wr = (sel == 0);
    cmp_a_wr = (sel == 1);
    cmp_b_wr = (sel == 2);
    mask_wr = (sel == 3);
    flag_wr = (sel == 4);
    irq_ack = (sel == 5) ? v[2:0] : 3'h0;
    @(negedge clk_sys);
    {cnt_wr, cmp_a_wr, cmp_b_wr, mask_wr, flag_wr} = 5'h00;
    irq_ack = 3'h0;
  endtask

  task automatic pulse_tick(input logic [3:0] v);
    @(negedge clk_sys);
    pre_tick = v;
    @(negedge clk_sys);
    pre_tick = 4'h0;
  endtask

  task automatic wait_cnt(input logic [7:0] v);
    int i;
    for (i = 0; i < 600; i++) begin
      @(negedge clk_sys);
      if (counter_value === v) return;
    end
    num_errors++;
    $display("MISMATCH wait_cnt exp %h got %h", v, counter_value);
    report_and_stop();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    `CHK("counter", 8'h00, counter_value)
    `CHK("compares", 16'h0000, {cmp_a_rd, cmp_b_rd})
    `CHK("ctrl", 12'h000, {ctl_a_rd, ctl_b_rd})
    `CHK("flag_mask_irq", 9'h000, {flags, mask_rd, irq})
    `CHK("outputs", 2'b00, {out_a, out_b})
  endtask

  task automatic t_wrap();
    poke(3, 8'h01);
    poke(0, 8'hfd);
    set_ctrl(3'h0, CS_SYS, COM_OFF, 1'b0);
    wait_cnt(8'hff);
    `CHK("ovf_before", 1'b0, flags[FLG_OVF])
    @(negedge clk_sys);
    `CHK("wrap", 8'h00, counter_value)
    `CHK("ovf_flag", 1'b1, flags[FLG_OVF])
    `CHK("ovf_irq", 3'h1, irq)
    poke(0, 8'h80);
    `CHK("write_wins", 8'h80, counter_value)
  endtask

  task automatic t_clear();
    set_ctrl(3'h0, CS_STOP, COM_OFF, 1'b0);
    `CHK("all_flags", 3'h7, flags)
    poke(5, 8'h01);
    `CHK("ack_clear", 6'h30, {flags, irq})
    poke(4, 8'h02);
    `CHK("write_one", 3'h4, flags)
    poke(3, 8'h04);
    `CHK("mask_gate", 3'h4, irq)
    `CHK("mask_rd", 3'h4, mask_rd)
  endtask

  task automatic t_match();
    poke(4, 8'h07);
    poke(1, 8'h05);
    poke(0, 8'h04);
    `CHK("cmp_a_view", 8'h05, cmp_a_rd)
    set_ctrl(3'h0, CS_SYS, COM_OFF, 1'b0);
    wait_cnt(8'h05);
    `CHK("match_early", 1'b0, flags[FLG_CMPA])
    @(negedge clk_sys);
    `CHK("match_flag", 1'b1, flags[FLG_CMPA])
  endtask

  task automatic t_block();
    set_ctrl(3'h0, CS_STOP, COM_OFF, 1'b0);
    poke(4, 8'h07);
    poke(2, 8'h40);
    poke(0, 8'h40);
    set_ctrl(3'h0, CS_SYS, COM_OFF, 1'b0);
    wait_cnt(8'h42);
    `CHK("blocked", 1'b0, flags[FLG_CMPB])
  endtask

  task automatic t_source();
    logic [7:0] e;
    int         s;
    e = 8'h10;
    set_ctrl(3'h0, CS_STOP, COM_OFF, 1'b0);
    poke(0, e);
    repeat (10) @(negedge clk_sys);
    `CHK("stopped", e, counter_value)
    for (s = 2; s <= 5; s++) begin
      set_ctrl(3'h0, 3'(s), COM_OFF, 1'b0);
      pulse_tick(~(4'h1 << (s - 2)));
      pulse_tick(4'h1 << (s - 2));
      pulse_tick(4'h1 << (s - 2));
      e = e + 8'h02;
      @(negedge clk_sys);
      `CHK("presc", e, counter_value)
    end
    set_ctrl(3'h0, CS_EXT_RISE, COM_OFF, 1'b0);
    ext_pin = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK("ext_rise", e + 8'h01, counter_value)
    ext_pin = 1'b0;
    repeat (8) @(negedge clk_sys);
    `CHK("ext_rise_idle", e + 8'h01, counter_value)
    set_ctrl(3'h0, CS_EXT_FALL, COM_OFF, 1'b0);
    ext_pin = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK("ext_fall_idle", e + 8'h01, counter_value)
    ext_pin = 1'b0;
    repeat (8) @(negedge clk_sys);
    `CHK("ext_fall", e + 8'h02, counter_value)
  endtask

  task automatic t_ctc();
    set_ctrl(3'h0, CS_STOP, COM_OFF, 1'b0);
    poke(1, 8'h03);
    poke(0, 8'h00);
    set_ctrl(3'h2, CS_SYS, COM_OFF, 1'b0);
    wait_cnt(8'h03);
    @(negedge clk_sys);
    `CHK("ctc_clear", 8'h00, counter_value)
    repeat (8) begin
      @(negedge clk_sys);
      `CHK("ctc_top", 1'b1, counter_value <= 8'h03)
    end
  endtask

  task automatic t_force();
    logic [1:0] coms [5];
    logic       exp  [5];
    int         k;
    coms = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_OFF, COM_TOGGLE};
    exp = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    set_ctrl(3'h0, CS_STOP, COM_OFF, 1'b0);
    poke(4, 8'h07);
    for (k = 0; k < 5; k++) begin
      set_ctrl(3'h0, CS_STOP, coms[k], 1'b0);
      set_ctrl(3'h0, CS_STOP, coms[k], 1'b1);
      repeat (2) @(negedge clk_sys);
      `CHK("force_out", {exp[k], exp[k]}, {out_a, out_b})
    end
    `CHK("force_noflag", 3'h0, flags)
    set_ctrl(3'h0, CS_STOP, COM_SET, 1'b1);
    set_ctrl(3'h3, CS_STOP, COM_TOGGLE, 1'b0);
    repeat (2) @(negedge clk_sys);
    `CHK("mode_keep", 2'b11, {out_a, out_b})
    set_ctrl(3'h3, CS_STOP, COM_TOGGLE, 1'b1);
    repeat (2) @(negedge clk_sys);
    `CHK("pwm_noforce", 2'b11, {out_a, out_b})
    `CHK("ctrl_rd", 12'h5c0, {ctl_a_rd, ctl_b_rd})
  endtask

  task automatic t_buffer();
    set_ctrl(3'h3, CS_STOP, COM_OFF, 1'b0);
    poke(2, 8'h10);
    @(negedge clk_sys);
    `CHK("buf_view", 8'h10, cmp_b_rd)
    poke(4, 8'h07);
    poke(0, 8'h08);
    set_ctrl(3'h3, CS_SYS, COM_OFF, 1'b0);
    wait_cnt(8'h12);
    `CHK("buf_hold", 1'b0, flags[FLG_CMPB])
    wait_cnt(8'h42);
    `CHK("old_active", 1'b1, flags[FLG_CMPB])
    poke(4, 8'h07);
    wait_cnt(8'h00);
    `CHK("fast_ovf", 2'b01, {flags[FLG_CMPB], flags[FLG_OVF]})
    wait_cnt(8'h12);
    `CHK("buf_loaded", 1'b1, flags[FLG_CMPB])
  endtask

  task automatic t_phase();
    set_ctrl(3'h1, CS_STOP, COM_CLEAR, 1'b0);
    poke(4, 8'h07);
    poke(0, 8'hfd);
    set_ctrl(3'h1, CS_SYS, COM_CLEAR, 1'b0);
    wait_cnt(8'hff);
    @(negedge clk_sys);
    `CHK("pc_turn", 8'hfe, counter_value)
    wait_cnt(8'h00);
    @(negedge clk_sys);
    `CHK("pc_ovf", 9'h101, {flags[FLG_OVF], counter_value})
    wait_cnt(8'h05);
    `CHK("pc_out", 2'b01, {out_a, out_b})
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {ctl_a_wr, ctl_b_wr, cnt_wr, cmp_a_wr, cmp_b_wr, mask_wr, flag_wr} = 7'h00;
    ctl_a = '0;
    ctl_b = '0;
    {cnt_wdata, cmp_wdata} = 16'h0000;
    {mask_wdata, flag_wdata, irq_ack} = 9'h000;
    pre_tick = 4'h0;
    ext_pin = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_wrap();
    t_clear();
    t_match();
    t_block();
    t_source();
    t_ctc();
    t_force();
    t_buffer();
    t_phase();
    report_and_stop();
  end
endmodule
